// >>> hw/fcdma_top.v
// Four-channel bus-master transfer controller
`timescale 1ns/1ps
`include "fcdma_defines.vh"
// Operation
// - Acknowledge of granted channel pulses low then high for every byte.
// - Count bits 15:14 pick verify, write, read or illegal cycle.
// - Upper address byte is driven on data pins, then pins released.
// - Slave: low four address bits select register for write or read.
// - Write cycle: periph read plus memory write; read cycle the reverse.
// - Host reads status or a byte; writes mode or a byte.
// - Reset clears mode register, floats strobe/address/data pins, drives request low, acknowledges high.
// - As master, low address pins carry memory address bits 3:0.
// - Memory address bits 7:4 appear on dedicated outputs in cycles.
// - Chip select gates host strobes only while idle; they are refused from the moment the bus request is raised.
// - Inactive ready inserts wait states stretching the memory strobes.
// - Any enabled requesting channel raises the bus request output.
// - No transfer cycle starts before the bus grant arrives.
// - Address latch strobe pulses while upper byte is on data pins.
// - Bus float output is asserted throughout transfer cycles.
// - Last-cycle flag asserted when selected 14-bit count is zero.
// - With stop option set, last cycle clears that channel's enable.
// - Marker asserted every 128th cycle counted from block end.
// - Mode holds four channel enables and the stop option in bit 6; disabled idle.
// - Verify cycles take bus and acknowledge but issue no strobes.
// - Requests held until acknowledge; channel 0 has top priority.
// - Address bit 3 picks channel registers or mode/status register.
module fcdma_top #(
   parameter NCH = 4
) (
   input  wire           mclk,
   input  wire           rst_n,
   input  wire [NCH-1:0] channel_request,
   output reg  [NCH-1:0] channel_acknowledge_n,
   input  wire           cs_n,
   input  wire           host_rd_n,
   input  wire           host_wr_n,
   input  wire           periph_read_strobe_n_i,
   output reg            periph_read_strobe_n_o,
   output reg            periph_read_strobe_n_oe,
   input  wire           periph_write_strobe_n_i,
   output reg            periph_write_strobe_n_o,
   output reg            periph_write_strobe_n_oe,
   input  wire [3:0]     addr_lo_i,
   output reg  [3:0]     addr_lo_o,
   output reg            addr_lo_oe,
   output reg  [3:0]     addr_mid_o,
   output reg            addr_mid_oe,
   input  wire [7:0]     data_i,
   output reg  [7:0]     data_o,
   output reg            data_oe,
   input  wire           ready,
   output reg            bus_request_out,
   input  wire           bus_grant_in,
   output reg            memory_read_strobe_n_o,
   output reg            memory_write_strobe_n_o,
   output reg            mem_strobe_oe,
   output reg            upper_address_latch_strobe,
   output reg            master_cycle_bus_float,
   output reg            last_cycle_flag,
   output reg            mark_flag,
   output wire [7:0]     mode_out,
   output wire           rd_valid,
   input  wire           rd_ready,
   output wire [7:0]     rd_data,
   output wire           rd_in_ready
);
   // Inputs from outside, except rst_n and rd_ready, pass two flops before use
   reg [NCH-1:0] req_s1_q;
   reg [NCH-1:0] req_s2_q;
   reg [5:0]     ctl_s1_q;
   reg [5:0]     ctl_s2_q;
   reg [3:0]     a_s1_q;
   reg [3:0]     a_s2_q;
   reg [7:0]     d_s1_q;
   reg [7:0]     d_s2_q;
   reg           rdy_s1_q;
   reg           rdy_s2_q;

   wire [16*NCH-1:0] addr_flat;
   wire [16*NCH-1:0] cnt_flat;
   reg [7:0]     mode_q;
   reg [NCH-1:0] tcst_q;
   reg           ptr_q;
   reg [2:0]     st_q;
   reg [1:0]     ch_q;
   reg           wr_prev_q;
   reg           rd_prev_q;
   reg [7:0]     rd_byte_q;
   reg           rd_push_q;

   wire          cs_s  = ctl_s2_q[0];
   // Slave strobes may come on the host pins or the two-way strobe pins
   wire          rd_s  = ctl_s2_q[1] & ctl_s2_q[4];
   wire          wr_s  = ctl_s2_q[2] & ctl_s2_q[5];
   wire          grant = ctl_s2_q[3];
   wire          master = (st_q != `FCDMA_ST_IDLE);
   wire          sel   = ~cs_s & ~master;
   wire          wr_ev = sel & ~wr_s & wr_prev_q;
   wire          rd_ev = sel & ~rd_s & rd_prev_q;
   wire [NCH-1:0] live = req_s2_q & mode_q[NCH-1:0];
   wire [1:0]    rch   = a_s2_q[2:1];
   wire [1:0]    win;
   wire [15:0]   cur_a = addr_flat[16*ch_q +: 16];
   wire [15:0]   cur_c = cnt_flat[16*ch_q +: 16];
   wire [1:0]    ctype = cur_c[`FCDMA_TYPE_HI:`FCDMA_TYPE_LO];
   wire          tc_now = (cur_c[`FCDMA_CNT_MSB:0] == 14'h0000);
   // Marker counts from block end: remaining count low seven bits all ones
   wire          mk_now = (cur_c[`FCDMA_MARK_WIDTH-1:0] ==
                           `FCDMA_MARK_MASK) & ~tc_now;

   assign mode_out = mode_q;

   // Fixed priority, channel 0 highest
   assign win = live[0] ? 2'h0 : live[1] ? 2'h1 :
                live[2] ? 2'h2 : 2'h3;

   fcdma_skid #(.WIDTH(8)) u_rdbuf (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (rd_push_q),
      .in_ready  (rd_in_ready),
      .in_data   (rd_byte_q),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   // One register pair per channel; host bytes and the post-cycle step
   // never meet, since host access is refused while master
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_chan
         reg [15:0] addr_q;
         reg [15:0] cnt_q;
         wire       hit  = wr_ev & ~a_s2_q[`FCDMA_REG_SEL_BIT] &
                           (rch == g);
         wire       step = (st_q == `FCDMA_ST_END) & (ch_q == g);
         always @(posedge mclk) begin
            if (!rst_n) begin
               addr_q <= 16'h0000;
               cnt_q  <= 16'h0000;
            end else if (hit) begin
               if (a_s2_q[0]) begin
                  if (ptr_q) cnt_q[15:8] <= d_s2_q;
                  else       cnt_q[7:0]  <= d_s2_q;
               end else begin
                  if (ptr_q) addr_q[15:8] <= d_s2_q;
                  else       addr_q[7:0]  <= d_s2_q;
               end
            end else if (step) begin
               addr_q <= addr_q + 16'h0001;
               // Type bits ride along unchanged
               cnt_q  <= {cnt_q[`FCDMA_TYPE_HI:`FCDMA_TYPE_LO],
                          cnt_q[`FCDMA_CNT_MSB:0] - 14'h0001};
            end
         end
         assign addr_flat[16*g +: 16] = addr_q;
         assign cnt_flat[16*g +: 16]  = cnt_q;
      end
   endgenerate

   always @(posedge mclk) begin
      req_s1_q <= channel_request;
      req_s2_q <= req_s1_q;
      ctl_s1_q <= {periph_write_strobe_n_i, periph_read_strobe_n_i,
                   bus_grant_in, host_wr_n, host_rd_n, cs_n};
      ctl_s2_q <= ctl_s1_q;
      a_s1_q   <= addr_lo_i;
      a_s2_q   <= a_s1_q;
      d_s1_q   <= data_i;
      d_s2_q   <= d_s1_q;
      rdy_s1_q <= ready;
      rdy_s2_q <= rdy_s1_q;
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         mode_q    <= 8'h00;
         tcst_q    <= {NCH{1'b0}};
         ptr_q     <= 1'b0;
         st_q      <= `FCDMA_ST_IDLE;
         ch_q      <= 2'h0;
         wr_prev_q <= 1'b1;
         rd_prev_q <= 1'b1;
         rd_byte_q <= 8'h00;
         rd_push_q <= 1'b0;
      end else begin
         wr_prev_q <= wr_s;
         rd_prev_q <= rd_s;
         rd_push_q <= 1'b0;
         // Host write: decode and load one byte or mode
         if (wr_ev) begin
            if (a_s2_q[`FCDMA_REG_SEL_BIT]) begin
               mode_q <= d_s2_q;
            end else begin
               // Channel bytes land in the per-channel block
               ptr_q <= ~ptr_q;
            end
         end
         // Host read captured into buffer; dropped if buffer is full
         if (rd_ev & rd_in_ready) begin
            rd_push_q <= 1'b1;
            if (a_s2_q[`FCDMA_REG_SEL_BIT]) begin
               rd_byte_q <= {4'h0, tcst_q};
               tcst_q    <= {NCH{1'b0}};
            end else begin
               if (a_s2_q[0])
                  rd_byte_q <= cnt_flat[16*rch + 8*ptr_q +: 8];
               else
                  rd_byte_q <= addr_flat[16*rch + 8*ptr_q +: 8];
               ptr_q <= ~ptr_q;
            end
         end
         case (st_q)
            `FCDMA_ST_IDLE: begin
               // A grant left over from the last burst must drop first
               if (|live & ~grant)
                  st_q <= `FCDMA_ST_HOLD;
            end
            `FCDMA_ST_HOLD: begin
               if (~|live)
                  st_q <= `FCDMA_ST_IDLE;
               else if (grant) begin
                  ch_q <= win;
                  st_q <= `FCDMA_ST_ADDR;
               end
            end
            `FCDMA_ST_ADDR:   st_q <= `FCDMA_ST_STROBE;
            `FCDMA_ST_STROBE: st_q <= `FCDMA_ST_WAIT;
            `FCDMA_ST_WAIT: begin
               if (rdy_s2_q)
                  st_q <= `FCDMA_ST_END;
            end
            `FCDMA_ST_END: begin
               if (tc_now) begin
                  tcst_q[ch_q] <= 1'b1;
                  if (mode_q[`FCDMA_MODE_TCSTOP])
                     mode_q[ch_q] <= 1'b0;
               end
               st_q <= `FCDMA_ST_HOLD;
            end
            default: st_q <= `FCDMA_ST_IDLE;
         endcase
      end
   end

   // Output decode from state; floats when idle
   always @* begin
      channel_acknowledge_n      = {NCH{1'b1}};
      periph_read_strobe_n_o     = 1'b1;
      periph_write_strobe_n_o    = 1'b1;
      memory_read_strobe_n_o     = 1'b1;
      memory_write_strobe_n_o    = 1'b1;
      periph_read_strobe_n_oe    = 1'b0;
      periph_write_strobe_n_oe   = 1'b0;
      mem_strobe_oe              = 1'b0;
      addr_lo_o                  = cur_a[3:0];
      addr_lo_oe                 = 1'b0;
      addr_mid_o                 = cur_a[7:4];
      addr_mid_oe                = 1'b0;
      data_o                     = cur_a[15:8];
      data_oe                    = 1'b0;
      upper_address_latch_strobe = 1'b0;
      master_cycle_bus_float     = 1'b0;
      last_cycle_flag            = 1'b0;
      mark_flag                  = 1'b0;
      bus_request_out            = (st_q != `FCDMA_ST_IDLE);
      case (st_q)
         `FCDMA_ST_ADDR, `FCDMA_ST_STROBE, `FCDMA_ST_WAIT,
         `FCDMA_ST_END: begin
            master_cycle_bus_float   = 1'b1;
            addr_lo_oe               = 1'b1;
            addr_mid_oe              = 1'b1;
            periph_read_strobe_n_oe  = 1'b1;
            periph_write_strobe_n_oe = 1'b1;
            mem_strobe_oe            = 1'b1;
            last_cycle_flag          = tc_now;
            mark_flag                = mk_now;
            if (st_q == `FCDMA_ST_ADDR) begin
               data_oe                    = 1'b1;
               upper_address_latch_strobe = 1'b1;
            end else begin
               channel_acknowledge_n[ch_q] = 1'b0;
               if (st_q != `FCDMA_ST_END) begin
                  // Verify and illegal types issue no strobes
                  if (ctype == `FCDMA_TYPE_WRITE) begin
                     periph_read_strobe_n_o  = 1'b0;
                     memory_write_strobe_n_o = 1'b0;
                  end else if (ctype == `FCDMA_TYPE_READ) begin
                     periph_write_strobe_n_o = 1'b0;
                     memory_read_strobe_n_o  = 1'b0;
                  end
               end
            end
         end
         default: begin
         end
      endcase
   end
endmodule // fcdma_top

// >>> hw/fcdma_defines.vh
// Shared constants for the four-channel transfer controller
`ifndef FCDMA_DEFINES_VH
`define FCDMA_DEFINES_VH
`define FCDMA_TYPE_HI       15
`define FCDMA_TYPE_LO       14
`define FCDMA_CNT_MSB       13
`define FCDMA_TYPE_VERIFY   2'h0
`define FCDMA_TYPE_WRITE    2'h1
`define FCDMA_TYPE_READ     2'h2
`define FCDMA_REG_SEL_BIT   3
`define FCDMA_MODE_TCSTOP   6
`define FCDMA_MARK_MASK     7'h7F
`define FCDMA_MARK_WIDTH    7
`define FCDMA_ST_IDLE       3'h0
`define FCDMA_ST_HOLD       3'h1
`define FCDMA_ST_ADDR       3'h2
`define FCDMA_ST_STROBE     3'h3
`define FCDMA_ST_WAIT       3'h4
`define FCDMA_ST_END        3'h5
`endif

// >>> hw/fcdma_skid.v
// Two-entry buffer on the host read-data path
`timescale 1ns/1ps
module fcdma_skid #(
   parameter WIDTH = 8
) (
   input  wire             mclk,
   input  wire             rst_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_q [0:1];
   reg             wr_q;
   reg             rd_q;
   reg [1:0]       cnt_q;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge mclk) begin
      if (!rst_n) begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q        <= ~wr_q;
         end
         if (pop)
            rd_q <= ~rd_q;
         if (push & ~pop)
            cnt_q <= cnt_q + 2'h1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 2'h1;
      end
   end
endmodule // fcdma_skid

// >>> tb/fcdma_top_asserts.sv
// Port-level assertions for the transfer controller
`timescale 1ns/1ps
module fcdma_chk (
   input wire       mclk,
   input wire       rst_n,
   input wire [3:0] channel_acknowledge_n,
   input wire       ready,
   input wire       bus_grant_in,
   input wire       periph_read_strobe_n_o,
   input wire       periph_write_strobe_n_o,
   input wire       memory_read_strobe_n_o,
   input wire       memory_write_strobe_n_o,
   input wire       mem_strobe_oe,
   input wire       periph_read_strobe_n_oe,
   input wire       periph_write_strobe_n_oe,
   input wire       addr_lo_oe,
   input wire       addr_mid_oe,
   input wire       data_oe,
   input wire       upper_address_latch_strobe,
   input wire       master_cycle_bus_float,
   input wire       bus_request_out,
   input wire       last_cycle_flag,
   input wire       mark_flag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ack_one_chan_a: assert property (
      channel_acknowledge_n != 4'hF |-> master_cycle_bus_float &&
      $onehot(~channel_acknowledge_n)) else $error("stray acknowledge");
   ack_release_a: assert property (
      channel_acknowledge_n != 4'hF |-> ##[1:24]
      channel_acknowledge_n == 4'hF) else $error("acknowledge stuck");
   addr_phase_a: assert property (
      upper_address_latch_strobe |-> data_oe ##1 !data_oe)
      else $error("upper address phase");
   strobe_pair_a: assert property (
      mem_strobe_oe |-> memory_write_strobe_n_o == periph_read_strobe_n_o
      && memory_read_strobe_n_o == periph_write_strobe_n_o)
      else $error("strobe pairing");
   wait_hold_a: assert property (
      (!ready && !(memory_read_strobe_n_o && memory_write_strobe_n_o))[*3]
      |=> !(memory_read_strobe_n_o && memory_write_strobe_n_o))
      else $error("wait state skipped");
   grant_first_a: assert property (
      $rose(master_cycle_bus_float) |-> bus_request_out &&
      $past(bus_grant_in)) else $error("cycle without grant");
   flag_cycle_a: assert property (
      last_cycle_flag || mark_flag |-> master_cycle_bus_float)
      else $error("flag outside cycle");
   reset_quiet_a: assert property (disable iff (1'b0)
      !rst_n |=> !data_oe && !mem_strobe_oe && !bus_request_out)
      else $error("outputs driven in reset");
   pin_drive_a: assert property (
      (addr_lo_oe && addr_mid_oe && periph_read_strobe_n_oe &&
      periph_write_strobe_n_oe && mem_strobe_oe) == master_cycle_bus_float)
      else $error("pin drive mismatch");
endmodule // fcdma_chk

bind fcdma_top fcdma_chk chk_u (.*);

// >>> tb/fcdma_far_model.sv
// Bus-holder and memory-ready model at the controller's far side
`timescale 1ns/1ps
module fcdma_far_model (
   input  wire mclk,
   input  wire rst_n,
   input  wire slow,
   input  wire bus_request_out,
   input  wire mem_low,
   output wire bus_grant_in,
   output wire ready
);
   logic [2:0] hold_q = 3'h0;
   logic [2:0] wait_q = 3'h0;
   always @(posedge mclk) begin
      if (!rst_n || !bus_request_out) begin
         hold_q <= 3'h0;
      end else if (hold_q != 3'h7) begin
         hold_q <= hold_q + 3'h1;
      end
      if (!mem_low) begin
         wait_q <= 3'h0;
      end else if (wait_q != 3'h7) begin
         wait_q <= wait_q + 3'h1;
      end
   end
   // Grant lags the request; held until request drops
   assign bus_grant_in = hold_q > (slow ? 3'h4 : 3'h1);
   assign ready = !slow || wait_q > 3'h4;
endmodule // fcdma_far_model

// >>> tb/testbench.sv
// Self-checking bench for the four-channel transfer controller
`timescale 1ns/1ps
module testbench;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cs_n = 1'b1;
   logic        host_rd_n = 1'b1;
   logic        host_wr_n = 1'b1;
   logic        rd_ready = 1'b0;
   logic        slow = 1'b0;
   logic [3:0]  channel_request = 4'h0;
   logic [3:0]  ha = 4'h0;
   logic [3:0]  pa = 4'hF;
   logic [7:0]  hd = 8'h00;
   logic [15:0] exp_a = 16'h0000;
   int          miscompares = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          acks, tcs, marks, wc, rc;
   wire [3:0]   channel_acknowledge_n, addr_lo_o, addr_mid_o, addr_lo_i;
   wire [7:0]   data_o, data_i, mode_out, rd_data;
   wire         periph_read_strobe_n_o, periph_read_strobe_n_oe, ready;
   wire         periph_write_strobe_n_o, periph_write_strobe_n_oe;
   wire         addr_lo_oe, addr_mid_oe, data_oe, bus_request_out;
   wire         memory_read_strobe_n_o, memory_write_strobe_n_o, mem_low;
   wire         mem_strobe_oe, upper_address_latch_strobe, bus_grant_in;
   wire         master_cycle_bus_float, last_cycle_flag, mark_flag;
   wire         rd_valid, rd_in_ready;
   // Two-way strobe inputs idle high; host uses its own strobes
   wire         periph_read_strobe_n_i = 1'b1;
   wire         periph_write_strobe_n_i = 1'b1;
   assign addr_lo_i = addr_lo_oe ? addr_lo_o : ha;
   assign data_i = data_oe ? data_o : hd;
   assign mem_low = mem_strobe_oe &&
                    !(memory_read_strobe_n_o && memory_write_strobe_n_o);
   fcdma_top dut_u (.*);
   fcdma_far_model far_u (.*);
   always #12.5 mclk = ~mclk;
   always @(negedge mclk) begin
      if (upper_address_latch_strobe) begin
         chk({data_o, addr_mid_o, addr_lo_o}, exp_a);
         exp_a = exp_a + 16'h1;
      end
      if (channel_acknowledge_n != 4'hF && pa == 4'hF) begin
         acks++;
         tcs += last_cycle_flag;
         marks += mark_flag;
      end
      wc += (mem_strobe_oe && !memory_write_strobe_n_o);
      rc += (mem_strobe_oe && !memory_read_strobe_n_o);
      pa = channel_acknowledge_n;
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic hacc(input logic wr, input logic [3:0] a,
                       input logic [7:0] d);
      @(negedge mclk);
      ha = a;
      hd = d;
      cs_n = 1'b0;
      host_wr_n = !wr;
      host_rd_n = wr;
      repeat (4) @(negedge mclk);
      {cs_n, host_wr_n, host_rd_n} = 3'h7;
      repeat (3) @(negedge mclk);
   endtask
   task automatic pop(input logic [7:0] e);
      int n;
      rd_ready = 1'b1;
      for (n = 0; n < 20 && rd_valid !== 1'b1; n++) @(negedge mclk);
      chk(rd_data, e);
      @(negedge mclk);
      rd_ready = 1'b0;
   endtask
   task automatic setch(input logic [1:0] c, input logic [15:0] a, n);
      hacc(1'b1, {1'b0, c, 1'b0}, a[7:0]);
      hacc(1'b1, {1'b0, c, 1'b0}, a[15:8]);
      hacc(1'b1, {1'b0, c, 1'b1}, n[7:0]);
      hacc(1'b1, {1'b0, c, 1'b1}, n[15:8]);
   endtask
   task automatic rd16(input logic [3:0] a, input logic [15:0] e);
      hacc(1'b0, a, 8'h00);
      pop(e[7:0]);
      hacc(1'b0, a, 8'h00);
      pop(e[15:8]);
   endtask
   task automatic t_regs;
      setch(2'h1, 16'hC3A5, 16'h8F0E);
      rd16(4'h2, 16'hC3A5);
      rd16(4'h3, 16'h8F0E);
      channel_request = 4'h2;
      repeat (12) @(negedge mclk);
      chk(bus_request_out, 1'b0);
      chk(mode_out, 8'h00);
      channel_request = 4'h0;
      $display("test regs done");
   endtask
   task automatic t_buf;
      repeat (2) hacc(1'b0, 4'h8, 8'h00);
      chk(rd_in_ready, 1'b0);
      hacc(1'b0, 4'h8, 8'h00);
      repeat (2) pop(8'h00);
      repeat (2) @(negedge mclk);
      chk(rd_valid, 1'b0);
      $display("test buffer done");
   endtask
   task automatic t_xfer(input logic [1:0] c, t, input int n, mk,
                         input logic s);
      logic [15:0] b;
      int i;
      b = 16'h12F0 ^ {2'h0, c, 12'h000};
      setch(c, b, {t, 14'(n - 1)});
      exp_a = b;
      {acks, tcs, marks, wc, rc} = 0;
      slow = s;
      hacc(1'b1, 4'h8, 8'h40 | (8'h01 << c));
      channel_request[c] = 1'b1;
      if (s) begin
         for (i = 0; i < 60 && !master_cycle_bus_float; i++) @(negedge mclk);
         hacc(1'b1, 4'h8, 8'h00);
      end
      for (i = 0; i < 3000 && mode_out[c] !== 1'b0; i++) @(negedge mclk);
      channel_request[c] = 1'b0;
      chk(acks, n);
      chk(tcs, 1);
      chk(marks, mk);
      chk(mode_out[c], 1'b0);
      chk({wc != 0, rc != 0}, {t == 2'h1, t == 2'h2});
      chk(wc + rc >= 5 * n, s);
      rd16({1'b0, c, 1'b1}, {t, 14'h3FFF});
      hacc(1'b0, 4'h8, 8'h00);
      pop(8'h01 << c);
      $display("test transfer %0d done", c);
   endtask
   task automatic t_prio;
      int i;
      setch(2'h2, 16'h5000, 16'h0000);
      setch(2'h3, 16'h5001, 16'h0000);
      exp_a = 16'h5000;
      hacc(1'b1, 4'h8, 8'h4C);
      channel_request = 4'hC;
      for (i = 0; i < 60 && channel_acknowledge_n === 4'hF; i++)
         @(negedge mclk);
      chk(channel_acknowledge_n, 4'hB);
      for (i = 0; i < 200 && mode_out[3:2] !== 2'h0; i++) @(negedge mclk);
      channel_request = 4'h0;
      chk(exp_a, 16'h5002);
      $display("test priority done");
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      repeat (2) @(negedge mclk);
      t_regs();
      t_buf();
      t_xfer(2'h0, 2'h1, 128, 1, 1'b0);
      t_xfer(2'h1, 2'h2, 2, 0, 1'b1);
      t_xfer(2'h2, 2'h0, 3, 0, 1'b0);
      t_xfer(2'h3, 2'h3, 1, 0, 1'b0);
      t_prio();
      final_report();
   end
endmodule // testbench
